// ### cmc_pkg.sv
/*
  Package for the mode controller: mode encodings, field widths, reset values
  and the packed structs that carry channel and global state.
  Assumes one clock domain and a single design module that imports it.
*/
// Function
// - one global state, per-channel state
// - global sleep gates clock, registers hold
// - sleep: reads work, writes ignored
// - global reset clears fields, config writable
// - global halt stops all, tests configurable
// - communication only in global operating
// - channel sleep stops clock, holds, ignores writes
// - channel reset clears channel fields, configurable
// - channel halt leaves bus, tests configurable
// - operation reports one communication status
// - global operating/halt effect on channels
// - global reset forces channels to reset, except channels in sleep
// - no sleep with channels active
// - bus lock blocks channel halt
// - both resets clear channel counters, flags; global reset leaves a channel in channel sleep uncleared
// - only global reset clears global fields
// - transmit-mode common FIFO cleared by both, except channel reset entered from channel sleep
// - receive-mode common FIFO cleared globally only
`default_nettype none
package cmc_pkg;
  typedef enum logic [1:0] {
    GM_OPER  = 2'b00,
    GM_RESET = 2'b01,
    GM_HALT  = 2'b10,
    GM_SLEEP = 2'b11
  } cmc_gmode_t;
  typedef enum logic [1:0] {
    CM_OPER  = 2'b00,
    CM_RESET = 2'b01,
    CM_HALT  = 2'b10,
    CM_SLEEP = 2'b11
  } cmc_cmode_t;
  typedef enum logic [1:0] {
    CS_IDLE  = 2'b00,
    CS_RX    = 2'b01,
    CS_TX    = 2'b10,
    CS_BUSOFF = 2'b11
  } cmc_comm_t;
  localparam int CNT_W   = 8;
  localparam int CRC_W   = 15;
  localparam int TS_W    = 16;
  localparam int FMC_W   = 6;
  localparam int TPS_W   = 4;
  localparam int TMS_W   = 2;
  localparam int EFL_W   = 15;
  localparam int GEF_W   = 5;
  localparam int NRXB    = 16;
  localparam int NRXF    = 2;
  localparam int NTXB    = 4;
  localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
  localparam logic [CRC_W-1:0] CRC_RST = 15'h0000;
  localparam logic [TS_W-1:0]  TS_RST  = 16'h0000;
  typedef struct packed {
    logic [TMS_W-1:0] test_select;
    logic             test_enable;
    logic [CNT_W-1:0] receive_error_count;
    logic [CNT_W-1:0] transmit_error_count;
    logic [EFL_W-1:0] err_flags;
    logic [NTXB-1:0]  tx_req;
    logic [NTXB-1:0]  tx_hist;
    logic [CRC_W-1:0] crc;
  } cmc_chan_t;
  typedef struct packed {
    logic             enable;
    logic [FMC_W-1:0] msg_count;
    logic             irq;
    logic             lost;
    logic             full;
    logic             empty;
  } cmc_cfifo_t;
  // channel-side events and updates from the protocol engine
  typedef struct packed {
    logic             rx_active;
    logic             tx_active;
    logic             bus_off;
    logic             bus_lock;
    logic             upd;
    cmc_chan_t        val;
  } cmc_chev_t;
endpackage : cmc_pkg
`default_nettype wire

// ### cmc_mode_ctrl.sv
/*
  Global and per-channel mode controller with reset-clearing of state fields.
  Assumes software writes arrive as one-cycle strobes on clk and that the
  protocol engine reports events on the same clock; bus pins are not here.
*/
`default_nettype none
module cmc_mode_ctrl #(
  parameter int NCH = 1
) (
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic                         module_enable_bit,
  input  wire logic                         gmode_wr,
  input  wire cmc_pkg::cmc_gmode_t          gmode_req,
  input  wire logic [NCH-1:0]               cmode_wr,
  input  wire cmc_pkg::cmc_cmode_t          channel_mode_request [NCH],
  input  wire logic                         cfg_wr,
  input  wire cmc_pkg::cmc_chan_t           cfg_chan [NCH],
  input  wire logic                         cfifo_tx_mode,
  input  wire logic                         cfifo_upd,
  input  wire cmc_pkg::cmc_cfifo_t          cfifo_val,
  input  wire logic                         gbl_upd,
  input  wire logic [cmc_pkg::GEF_W-1:0]    gbl_err_set,
  input  wire logic [cmc_pkg::NRXB-1:0]     rx_new_set,
  input  wire logic [cmc_pkg::NRXF-1:0]     rx_fifo_en_wr,
  input  wire logic                         ram_test_wr,
  input  wire logic [cmc_pkg::TPS_W-1:0]    ram_test_page_select_wr,
  input  wire logic                         ram_test_enable_wr,
  input  wire logic                         ts_tick,
  input  wire cmc_pkg::cmc_chev_t           chev [NCH],
  output cmc_pkg::cmc_gmode_t               gmode,
  output cmc_pkg::cmc_cmode_t               cmode [NCH],
  output logic                              global_halted_state,
  output logic [NCH-1:0]                    channel_halted_state,
  output logic [NCH-1:0]                    bus_off_state,
  output cmc_pkg::cmc_comm_t                comm_state [NCH],
  output logic [NCH-1:0]                    comm_allowed,
  output logic [NCH-1:0]                    test_cfg_allowed,
  output logic [NCH-1:0]                    chan_clk_en,
  output logic                              module_clk_en,
  output logic                              gmode_done,
  output logic [NCH-1:0]                    cmode_done,
  output logic [NCH-1:0]                    cmode_refused,
  output cmc_pkg::cmc_chan_t                chan_state [NCH],
  output cmc_pkg::cmc_cfifo_t               cfifo_state,
  output logic [cmc_pkg::GEF_W-1:0]         gbl_err_flags,
  output logic [cmc_pkg::TS_W-1:0]          timestamp_count,
  output logic [cmc_pkg::NRXB-1:0]          rx_buffer_new_data,
  output logic [cmc_pkg::NRXF-1:0]          rx_fifo_enable,
  output logic [cmc_pkg::TPS_W-1:0]         ram_test_page_select,
  output logic                              ram_test_enable
);
  import cmc_pkg::*;

  cmc_gmode_t              gmode_r;
  cmc_cmode_t              cmode_r [NCH];
  cmc_chan_t               chan_r [NCH];
  cmc_cfifo_t              cfifo_r;
  logic [GEF_W-1:0]        gerr_r;
  logic [TS_W-1:0]         ts_r;
  logic [NRXB-1:0]         rxnew_r;
  logic [NRXF-1:0]         rxfe_r;
  logic [TPS_W-1:0]        rtps_r;
  logic                    ram_test_enable_r;
  logic                    gdone_r;
  logic [NCH-1:0]          cdone_r;
  logic [NCH-1:0]          crefuse_r;
  cmc_chan_t               chan_zero;

  assign chan_zero = '0;

  // global request accepted only with module enabled
  wire       g_awake  = (gmode_r != GM_SLEEP);
  wire       g_wr_ok  = module_enable_bit & gmode_wr;
  logic      any_active;
  always_comb begin
    any_active = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      if ((cmode_r[i] == CM_OPER) || (cmode_r[i] == CM_HALT)) begin
        any_active = 1'b1;
      end
    end
  end
  wire       g_sleep_bad = (gmode_req == GM_SLEEP) & any_active;
  wire       g_take      = g_wr_ok & ~g_sleep_bad;
  wire       g_to_reset  = g_take & (gmode_req == GM_RESET) & (gmode_r != GM_RESET);
  wire       g_to_halt   = g_take & (gmode_req == GM_HALT);
  wire       g_to_sleep  = g_take & (gmode_req == GM_SLEEP);

  // channel mode after a global change
  function automatic cmc_cmode_t forced_mode(input cmc_cmode_t cur, input cmc_gmode_t req);
    forced_mode = cur;
    unique case (req)
      GM_OPER:  forced_mode = cur;
      GM_HALT:  forced_mode = (cur == CM_OPER) ? CM_HALT : cur;
      GM_RESET: forced_mode = (cur == CM_SLEEP) ? CM_SLEEP : CM_RESET;
      GM_SLEEP: forced_mode = (cur == CM_RESET) ? CM_SLEEP : cur;
    endcase
  endfunction : forced_mode

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gmode_r <= GM_RESET;
      gdone_r <= 1'b0;
    end else begin
      gdone_r <= g_take;
      if (g_take) begin
        gmode_r <= gmode_req;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || g_to_reset) begin
      gerr_r  <= '0;
      ts_r    <= TS_RST;
      rxnew_r <= '0;
      rxfe_r  <= '0;
      rtps_r  <= '0;
      ram_test_enable_r  <= 1'b0;
    end else if (g_awake) begin
      if (gbl_upd) begin
        gerr_r  <= gerr_r | gbl_err_set;
        rxnew_r <= rxnew_r | rx_new_set;
      end
      if (ts_tick) begin
        ts_r <= ts_r + 16'h0001;
      end
      if (gmode_r == GM_RESET) begin
        rxfe_r <= rx_fifo_en_wr;
      end
      // RAM test set only in halt
      if (ram_test_wr && (gmode_r == GM_HALT)) begin
        rtps_r <= ram_test_page_select_wr;
        ram_test_enable_r <= ram_test_enable_wr;
      end
    end
  end

  logic any_ch_reset;
  always_comb begin
    any_ch_reset = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      if (cmode_wr[i] && module_enable_bit && channel_mode_request[i] == CM_RESET
          && cmode_r[i] != CM_RESET && cmode_r[i] != CM_SLEEP && !g_take) begin
        any_ch_reset = 1'b1;
      end
    end
  end

  // tx mode cleared by both (not channel reset from channel sleep); rx mode only by global
  wire cf_clr = g_to_reset | (cfifo_tx_mode & any_ch_reset);
  always_ff @(posedge clk) begin
    if (!rst_n || cf_clr) begin
      cfifo_r <= '0;
    end else if (g_awake && cfifo_upd) begin
      cfifo_r <= cfifo_val;
    end
  end

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    wire c_wr      = cmode_wr[c] & module_enable_bit & g_awake;
    wire c_refuse  = c_wr & (channel_mode_request[c] == CM_HALT) & chan_r[c].err_flags[0];
    // channel mode requests cannot exceed global mode
    wire c_lawful  = ~((gmode_r == GM_RESET) & (channel_mode_request[c] != CM_RESET)
                       & (channel_mode_request[c] != CM_SLEEP))
                     & ~((gmode_r == GM_HALT) & (channel_mode_request[c] == CM_OPER));
    wire c_take    = c_wr & ~c_refuse & c_lawful & ~g_take;
    wire c_asleep  = (cmode_r[c] == CM_SLEEP);
    // clear on entry into channel reset
    wire c_to_rst  = (c_take & (channel_mode_request[c] == CM_RESET) & (cmode_r[c] != CM_RESET))
                     | (g_to_reset & ~c_asleep);
    // configuration only in reset or halt
    wire c_cfg_ok  = cfg_wr & ~c_asleep & ((cmode_r[c] == CM_RESET) | (cmode_r[c] == CM_HALT)
                     | (gmode_r == GM_RESET));
    cmc_cmode_t c_nxt;
    assign c_nxt = g_take ? forced_mode(cmode_r[c], gmode_req)
                 : (c_take ? channel_mode_request[c] : cmode_r[c]);

    always_ff @(posedge clk) begin
      if (!rst_n) begin
        cmode_r[c]   <= CM_RESET;
        cdone_r[c]   <= 1'b0;
        crefuse_r[c] <= 1'b0;
      end else begin
        cdone_r[c]   <= c_take | (g_take & (c_nxt != cmode_r[c]));
        crefuse_r[c] <= c_refuse;
        cmode_r[c]   <= c_nxt;
      end
    end

    // channel fields; frozen in channel sleep
    always_ff @(posedge clk) begin
      if (!rst_n || c_to_rst) begin
        chan_r[c] <= chan_zero;
      end else if (g_awake && !c_asleep) begin
        if (c_cfg_ok) begin
          chan_r[c].test_select <= cfg_chan[c].test_select;
          chan_r[c].test_enable <= cfg_chan[c].test_enable;
        end else if (chev[c].upd) begin
          chan_r[c] <= chev[c].val;
        end
      end
    end

    // bus access only when both operating
    assign comm_allowed[c]         = (gmode_r == GM_OPER) & (cmode_r[c] == CM_OPER);
    assign test_cfg_allowed[c]     = (cmode_r[c] == CM_HALT);
    assign chan_clk_en[c]          = ~c_asleep & g_awake;
    assign channel_halted_state[c] = (cmode_r[c] == CM_HALT);
    assign bus_off_state[c]        = comm_allowed[c] & chev[c].bus_off;
    assign comm_state[c] = !comm_allowed[c] ? CS_IDLE
                         : chev[c].bus_off  ? CS_BUSOFF
                         : chev[c].tx_active ? CS_TX
                         : chev[c].rx_active ? CS_RX : CS_IDLE;
    assign cmode[c]      = cmode_r[c];
    assign chan_state[c] = chan_r[c];
  end

  // module clock gated in global sleep
  assign module_clk_en        = g_awake;
  assign gmode                = gmode_r;
  assign global_halted_state  = (gmode_r == GM_HALT);
  assign gmode_done           = gdone_r;
  assign cmode_done           = cdone_r;
  assign cmode_refused        = crefuse_r;
  assign cfifo_state          = cfifo_r;
  assign gbl_err_flags        = gerr_r;
  assign timestamp_count      = ts_r;
  assign rx_buffer_new_data   = rxnew_r;
  assign rx_fifo_enable       = rxfe_r;
  assign ram_test_page_select = rtps_r;
  assign ram_test_enable      = ram_test_enable_r;

endmodule : cmc_mode_ctrl
`default_nettype wire

// ### cmc_mode_props.sv
/*
  Port-level checker for the mode controller, one clock domain.
  Assumes it is bound onto cmc_mode_ctrl and sees channel 0 only.
*/
`default_nettype none
module cmc_mode_props #(
  parameter int NCH = 1
) (
  input wire logic                   clk,
  input wire logic                   rst_n,
  input wire logic                   module_enable_bit,
  input wire logic                   gmode_wr,
  input wire cmc_pkg::cmc_gmode_t    gmode_req,
  input wire logic [NCH-1:0]         cmode_wr,
  input wire cmc_pkg::cmc_cmode_t    channel_mode_request [NCH],
  input wire cmc_pkg::cmc_gmode_t    gmode,
  input wire cmc_pkg::cmc_cmode_t    cmode [NCH],
  input wire logic                   gmode_done,
  input wire logic [NCH-1:0]         cmode_refused,
  input wire logic [NCH-1:0]         comm_allowed,
  input wire logic [NCH-1:0]         chan_clk_en,
  input wire logic                   module_clk_en,
  input wire logic                   global_halted_state,
  input wire logic [NCH-1:0]         bus_off_state,
  input wire cmc_pkg::cmc_comm_t     comm_state [NCH],
  input wire cmc_pkg::cmc_chan_t     chan_state [NCH],
  input wire logic [cmc_pkg::TS_W-1:0] timestamp_count
);
  import cmc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic gtake = module_enable_bit && gmode_wr;
  gm_take_a: assert property (gtake && gmode_req != GM_SLEEP
    |=> gmode == $past(gmode_req) && gmode_done) else $error("global mode not taken");
  gdone_cause_a: assert property (gmode_done |-> $past(gtake))
    else $error("global done without request");
  halt_shift_a: assert property (gtake && gmode_req == GM_HALT && cmode[0] == CM_OPER
    |=> cmode[0] == CM_HALT) else $error("channel not halted");
  reset_force_a: assert property (gtake && gmode_req == GM_RESET
    && gmode != GM_RESET && cmode[0] != CM_SLEEP
    |=> cmode[0] == CM_RESET && chan_state[0].transmit_error_count == '0 && chan_state[0].crc == '0)
    else $error("global reset did not clear channel");
  sleep_block_a: assert property (gtake && gmode_req == GM_SLEEP
    && cmode[0] inside {CM_OPER, CM_HALT} |=> $stable(gmode)) else $error("sleep taken");
  lock_halt_a: assert property (module_enable_bit && cmode_wr[0] && !gmode_wr
    && channel_mode_request[0] == CM_HALT && chan_state[0].err_flags[0]
    && gmode inside {GM_OPER, GM_HALT} |=> cmode_refused[0] && $stable(cmode[0]))
    else $error("halt taken under bus lock");
  comm_gate_a: assert property (comm_allowed[0]
    |-> gmode == GM_OPER && cmode[0] == CM_OPER) else $error("comm outside operating");
  ghalt_a: assert property ($rose(gmode == GM_HALT)
    |-> global_halted_state && !comm_allowed[0]) else $error("halt still communicates");
  clk_gate_a: assert property (gmode == GM_SLEEP |-> !module_clk_en)
    else $error("module clock runs in sleep");
  chan_clk_a: assert property (cmode[0] == CM_SLEEP |-> !chan_clk_en[0])
    else $error("channel clock runs in sleep");
  sleep_hold_a: assert property ((gmode == GM_SLEEP)[*2]
    |-> $stable(timestamp_count) && $stable(chan_state[0])) else $error("sleep state moved");
  busoff_a: assert property (bus_off_state[0] && cmode[0] == CM_OPER
    |-> comm_state[0] == CS_BUSOFF) else $error("bus off not reported");
  cover property (gmode == GM_SLEEP);
  cover property (cmode_refused[0]);
  cover property (comm_state[0] == CS_RX);
endmodule : cmc_mode_props
bind cmc_mode_ctrl cmc_mode_props #(.NCH(NCH)) i_cmc_mode_props (.clk, .rst_n,
  .module_enable_bit, .gmode_wr, .gmode_req, .cmode_wr, .channel_mode_request, .gmode,
  .cmode, .gmode_done, .cmode_refused, .comm_allowed, .chan_clk_en, .module_clk_en,
  .global_halted_state, .bus_off_state, .comm_state, .chan_state, .timestamp_count);
`default_nettype wire

// ### cmc_node_model.sv
/*
  Behavioural far-side node for one channel: drives the engine event bundle.
  Assumes the bench calls its tasks; changes land on falling edges.
*/
`default_nettype none
module cmc_node_model (
  input  wire logic             clk,
  output var cmc_pkg::cmc_chev_t ev
);
  timeunit 1ns;
  timeprecision 1ns;
  import cmc_pkg::*;
  initial ev = '0;
  task automatic act(input logic rx, input logic tx, input logic bo);
    @(negedge clk);
    ev.rx_active = rx;
    ev.tx_active = tx;
    ev.bus_off = bo;
    #1;
  endtask : act
  task automatic post(input logic lock, input logic [CNT_W-1:0] transmit_error_count);
    @(negedge clk);
    ev.upd = 1'b1;
    ev.bus_lock = lock;
    ev.val = '0;
    ev.val.err_flags[0] = lock;
    ev.val.transmit_error_count = transmit_error_count;
    @(negedge clk);
    ev.upd = 1'b0;
  endtask : post
endmodule : cmc_node_model
`default_nettype wire

// ### testbench.sv
/*
  Self-checking bench for cmc_mode_ctrl with one channel.
  Assumes the node model on the far side and the bound checker.
*/
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin err_count++; \
  $display("mismatch %s exp %0h got %0h", n, e, s); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import cmc_pkg::*;
  localparam int NCH = 1;
  logic clk, rst_n, module_enable_bit, gmode_wr, cfg_wr, cfifo_tx_mode, cfifo_upd;
  logic gbl_upd, ram_test_wr, ram_test_enable_wr, ts_tick, gmode_done, ram_test_enable;
  logic global_halted_state, module_clk_en;
  logic [NCH-1:0] cmode_wr, channel_halted_state, bus_off_state, comm_allowed;
  logic [NCH-1:0] test_cfg_allowed, chan_clk_en, cmode_done, cmode_refused;
  logic [GEF_W-1:0] gbl_err_set, gbl_err_flags;
  logic [NRXB-1:0] rx_new_set, rx_buffer_new_data;
  logic [NRXF-1:0] rx_fifo_en_wr, rx_fifo_enable;
  logic [TPS_W-1:0] ram_test_page_select_wr, ram_test_page_select;
  logic [TS_W-1:0] timestamp_count;
  cmc_gmode_t gmode_req, gmode;
  cmc_cmode_t channel_mode_request [NCH], cmode [NCH];
  cmc_chan_t  cfg_chan [NCH], chan_state [NCH];
  cmc_chev_t  chev [NCH];
  cmc_comm_t  comm_state [NCH];
  cmc_cfifo_t cfifo_val, cfifo_state;
  int err_count, checked;
  cmc_mode_ctrl #(.NCH(NCH)) i_cmc_mode_ctrl (.*);
  cmc_node_model i_cmc_node_model (.clk(clk), .ev(chev[0]));
  task automatic gset(input cmc_gmode_t m);
    @(negedge clk);
    gmode_wr = 1'b1;
    gmode_req = m;
    @(negedge clk);
    gmode_wr = 1'b0;
  endtask : gset
  task automatic cset(input cmc_cmode_t m);
    @(negedge clk);
    cmode_wr = 1'b1;
    channel_mode_request[0] = m;
    @(negedge clk);
    cmode_wr = 1'b0;
  endtask : cset
  task automatic strobe(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask : strobe
  task complete_run;
    if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #100000;
    err_count++;
    complete_run();
  end
  initial begin
    {rst_n, module_enable_bit, gmode_wr, cmode_wr, cfg_wr, cfifo_upd, gbl_upd} = '0;
    {ram_test_wr, ts_tick, cfifo_tx_mode, cfifo_val, cfg_chan[0]} = '0;
    gmode_req = GM_RESET;
    channel_mode_request[0] = CM_RESET;
    gbl_err_set = 5'h11;
    rx_new_set = 16'h8001;
    rx_fifo_en_wr = 2'h1;
    ram_test_page_select_wr = 4'h5;
    ram_test_enable_wr = 1'b1;
    cfifo_val.enable = 1'b1;
    cfifo_val.msg_count = 6'h03;
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    `CHK("gmode", GM_RESET, gmode)
    `CHK("cmode", CM_RESET, cmode[0])
    gset(GM_OPER);
    `CHK("gm_off", GM_RESET, gmode)
    module_enable_bit = 1'b1;
    cfg_chan[0].test_enable = 1'b1;
    strobe(cfg_wr);
    strobe(gbl_upd);
    `CHK("tst_en", 1'b1, chan_state[0].test_enable)
    `CHK("rxf_en", 2'h1, rx_fifo_enable)
    `CHK("gef", 5'h11, gbl_err_flags)
    gset(GM_OPER);
    `CHK("g_done", 1'b1, gmode_done)
    `CHK("cm_keep", CM_RESET, cmode[0])
    cset(CM_OPER);
    `CHK("c_done", 1'b1, cmode_done[0])
    `CHK("comm_ok", 1'b1, comm_allowed[0])
    strobe(ts_tick);
    strobe(ts_tick);
    for (int i = 3; i >= 0; i--) begin
      i_cmc_node_model.act(i == 1, i == 2, i == 3);
      `CHK("comm", cmc_comm_t'(i[1:0]), comm_state[0])
      `CHK("bus_off", (i == 3), bus_off_state[0])
    end
    i_cmc_node_model.post(1'b1, 8'h05);
    cset(CM_HALT);
    `CHK("refused", 1'b1, cmode_refused[0])
    `CHK("cm_op", CM_OPER, cmode[0])
    i_cmc_node_model.post(1'b0, 8'h05);
    gset(GM_HALT);
    `CHK("cm_halt", CM_HALT, cmode[0])
    `CHK("ghalt", 1'b1, global_halted_state)
    `CHK("no_comm", 1'b0, comm_allowed[0])
    `CHK("ch_halt", 1'b1, channel_halted_state[0])
    `CHK("tst_cfg", 1'b1, test_cfg_allowed[0])
    strobe(ram_test_wr);
    `CHK("ram_test_enable", 1'b1, ram_test_enable)
    `CHK("rtps", 4'h5, ram_test_page_select)
    gset(GM_SLEEP);
    `CHK("no_sleep", GM_HALT, gmode)
    cfifo_tx_mode = 1'b1;
    strobe(cfifo_upd);
    cset(CM_RESET);
    `CHK("tec_clr", 8'h00, chan_state[0].transmit_error_count)
    `CHK("fifo_tx", 1'b0, cfifo_state.enable)
    `CHK("ts_keep", 16'h0002, timestamp_count)
    cset(CM_HALT);
    cfifo_tx_mode = 1'b0;
    strobe(cfifo_upd);
    cset(CM_RESET);
    `CHK("fifo_rx", 6'h03, cfifo_state.msg_count)
    gset(GM_RESET);
    `CHK("fifo_g", 6'h00, cfifo_state.msg_count)
    `CHK("ts_clr", 16'h0000, timestamp_count)
    `CHK("ram_test_enable_clr", 1'b0, ram_test_enable)
    `CHK("gef_clr", 5'h00, gbl_err_flags)
    `CHK("new_clr", 16'h0000, rx_buffer_new_data)
    gset(GM_SLEEP);
    `CHK("g_sleep", GM_SLEEP, gmode)
    `CHK("c_sleep", CM_SLEEP, cmode[0])
    `CHK("clk_off", 1'b0, module_clk_en)
    `CHK("ch_clk", 1'b0, chan_clk_en[0])
    cfg_chan[0].test_enable = 1'b1;
    strobe(cfg_wr);
    `CHK("no_wr", 1'b0, chan_state[0].test_enable)
    complete_run();
  end
endmodule : testbench
`default_nettype wire
